// ==== miss_ctrl_pkg.sv ====
// Purpose: Shared constants, carrier structs and state types for the
//          virtual cache miss controller.
// Assumes: One 20 MHz clock; 36-bit physical addresses; 32-byte lines.
// Notes:   Byte enables are active low, bit 0 steers the most significant
//          byte of the word.
`default_nettype none

package miss_ctrl_pkg;

   // ==========================================================
   // Geometry
   localparam int ADDR_W     = 36;
   localparam int WORD_W     = 32;
   localparam int LINE_WORDS = 8;
   localparam int WBUF_DEPTH = 4;
   localparam int CLK_MHZ    = 20;

   // ==========================================================
   // Counts and codes
   localparam logic [2:0] WBUF_FULL   = 3'h4;
   localparam logic [2:0] LAST_WORD   = 3'h7;
   localparam logic [3:0] BE_ALL      = 4'h0;
   localparam logic [3:0] BE_NONE     = 4'hf;
   localparam logic [1:0] SIZE_BYTE   = 2'h0;
   localparam logic [1:0] SIZE_HALF   = 2'h1;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      ST_IDLE, ST_DRAIN, ST_FILL, ST_VICTIM, ST_RBWR, ST_DELIVER, ST_REEN, ST_MERGE
   } state_type;

   // Processor request with lookup result from the tag logic
   typedef struct packed {
      logic              valid;
      logic              write;
      logic              cacheable;
      logic              dbl;
      logic              hit;
      logic              dirty;
      logic [1:0]        size;
      logic [ADDR_W-1:0] paddr;
      logic [63:0]       wdata;
   } proc_req_type;

   // One write buffer entry; four of them also form one line
   typedef struct packed {
      logic              dbl;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] w0;
      logic [WORD_W-1:0] w1;
   } wbuf_entry_type;

   // Word stream toward memory
   typedef struct packed {
      logic              valid;
      logic              last;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] data;
   } mem_wr_type;

   // Whole controller state
   typedef struct packed {
      state_type                        state;
      logic [3:0]                       fcnt;
      logic [3:0]                       vcnt;
      logic                             issued;
      wbuf_entry_type [WBUF_DEPTH-1:0]  wb;
      logic [1:0]                       wptr;
      logic [1:0]                       rptr;
      logic [2:0]                       count;
      logic                             line_mode;
      logic                             dr_active;
      logic [2:0]                       dr_word;
      logic [LINE_WORDS-1:0][WORD_W-1:0] rbuf;
      logic                             rb_valid;
      logic [WORD_W-1:0]                rdata;
   } ctrl_type;

   localparam ctrl_type CTRL_RESET = '0;

   // Active-low byte enables from size and byte offset
   function automatic logic [3:0] be_decode(input logic [1:0] size, input logic [1:0] a);
      logic [3:0] be;
      be = BE_NONE;
      if (size == SIZE_BYTE)
      begin
         be[a] = 1'b0;
      end
      else if (size == SIZE_HALF)
      begin
         if (a == 2'h0)
            be = 4'hc;
         else if (a == 2'h2)
            be = 4'h3;
      end
      else if (a == 2'h0)
      begin
         be = BE_ALL;
      end
      return be;
   endfunction

endpackage

`default_nettype wire

// ==== miss_ctrl.sv ====
// Purpose: Miss sequencing, write buffers and read buffer of a virtual
//          cache: stalls and strobes the integer unit, drives cache RAMs.
// Assumes: Memory returns line words in order 0..7; cache RAM read data is
//          valid in the cycle its word is selected.
// Notes:   Tag lookup results arrive with the processor request.
// Behaviour
// - Stall the processor while a request cannot be served.
// - Pulse the latch strobe only while stalled; processor captures data.
// - Processor drivers go off when the drive enable is negated.
// - Drive cache read enable low whenever the cache is read.
// - Four active-low byte enables allow byte, halfword, word writes.
// - Read miss: stall, drivers off, fill, deliver, strobe, drivers on, release.
// - Drivers back on at least one clock before releasing the stall.
// - Read misses run identically in copy-back and write-through mode.
// - Write-through write miss goes to buffer, invalidates tag, drains later.
// - Write-through write stalls only when all four entries are occupied.
// - Copy-back clean write miss: fill, drivers on, merge store, release.
// - Modified write miss: victim to write buffer, new line to read buffer, merge.
// - Write-through entries hold two words and their own address.
// - Copy-back victim uses all four entries as one line, one address.
// - Reset invalidates every write buffer entry.
// - Non-cacheable writes use entries; never mixed with a victim line.
// - Request the memory bus while any entry is valid; one line = one transfer.
// - With grant parked, chain the next transfer with no idle clock.
// - Further stores wait while every entry is occupied.
// - Read miss waits until the write buffer is empty, then fetches.
// - One-line read buffer overlaps victim write-back; reset invalidates it.
// - Enable bit 0 is the most significant byte; fills assert all four.
`timescale 1ns/100ps
`default_nettype none

module miss_ctrl
   import miss_ctrl_pkg::*;
(
   // Clock, reset, enable
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               ce,
   // Processor request and mode
   input  wire proc_req_type       req,
   input  wire logic               copy_back,
   input  wire logic [ADDR_W-1:0]  victim_addr,
   // Processor control
   output logic                    proc_stall_n,
   output logic                    proc_latch_strobe_n,
   output logic                    proc_bus_drive_en_n,
   output logic [WORD_W-1:0]       proc_rdata,
   // Cache RAM and tag control
   output logic                    cache_ram_rd_oe_n,
   output logic [3:0]              cache_ram_byte_wr_n,
   output logic [2:0]              cache_line_word,
   output logic [WORD_W-1:0]       cache_wdata,
   input  wire logic [WORD_W-1:0]  cache_rdata,
   output logic                    tag_inval,
   // Memory bus side
   output logic                    mbus_req,
   input  wire logic               mbus_grant,
   output logic                    mem_rd_req,
   output logic [ADDR_W-1:0]       mem_rd_addr,
   input  wire logic               mem_rd_valid,
   input  wire logic [WORD_W-1:0]  mem_rd_data,
   output mem_wr_type              mem_wr,
   input  wire logic               mem_wr_ready
);

   // ==========================================================
   // State
   ctrl_type r_reg;
   ctrl_type r_next;
   logic     wt_path;
   logic     wb_full;
   logic     push;
   logic     pop;
   logic     line_load;
   logic     dr_last;
   logic [1:0] dr_idx;
   wbuf_entry_type dr_ent;

   // Store path and fullness
   assign wt_path = !copy_back || !req.cacheable;
   assign wb_full = (r_reg.count == WBUF_FULL) || r_reg.line_mode;

   // Drain source selection; entry order follows the read pointer, or the word count in line mode
   assign dr_idx = r_reg.line_mode ? r_reg.dr_word[2:1] : r_reg.rptr;
   assign dr_ent = r_reg.wb[dr_idx];
   assign dr_last = r_reg.line_mode ? (r_reg.dr_word == LAST_WORD)
                                    : (r_reg.dr_word[0] == dr_ent.dbl);

   // ==========================================================
   // Output decode
   always_comb
   begin
      proc_stall_n        = 1'b1;
      proc_latch_strobe_n = 1'b1;
      proc_bus_drive_en_n = 1'b0;
      cache_ram_rd_oe_n   = 1'b1;
      cache_ram_byte_wr_n = BE_NONE;
      cache_line_word     = req.paddr[4:2];
      cache_wdata         = req.wdata[63:32];
      tag_inval           = 1'b0;
      mem_rd_req          = 1'b0;
      unique case (r_reg.state)
         ST_IDLE:
         begin
            if (req.valid && !req.write)
            begin
               cache_ram_rd_oe_n = !(req.cacheable && req.hit);
               proc_stall_n      = req.cacheable && req.hit;
            end
            else if (req.valid && wt_path)
            begin
               proc_stall_n = !wb_full;
               if (!wb_full && req.cacheable && req.hit)
                  cache_ram_byte_wr_n = be_decode(req.size, req.paddr[1:0]);
               tag_inval = !wb_full && req.cacheable && !req.hit;
            end
            else if (req.valid)
            begin
               proc_stall_n = req.hit;
               if (req.hit)
                  cache_ram_byte_wr_n = be_decode(req.size, req.paddr[1:0]);
            end
         end
         ST_DRAIN:
         begin
            proc_stall_n        = 1'b0;
            proc_bus_drive_en_n = 1'b1;
         end
         ST_FILL:
         begin
            proc_stall_n        = 1'b0;
            proc_bus_drive_en_n = 1'b1;
            mem_rd_req          = !r_reg.issued;
            cache_line_word     = r_reg.fcnt[2:0];
            cache_wdata         = mem_rd_data;
            if (mem_rd_valid)
               cache_ram_byte_wr_n = BE_ALL;
         end
         ST_VICTIM:
         begin
            proc_stall_n        = 1'b0;
            proc_bus_drive_en_n = 1'b1;
            mem_rd_req          = !r_reg.issued;
            cache_line_word     = r_reg.vcnt[2:0];
            cache_ram_rd_oe_n   = r_reg.vcnt[3];
         end
         ST_RBWR:
         begin
            proc_stall_n        = 1'b0;
            proc_bus_drive_en_n = 1'b1;
            cache_line_word     = r_reg.vcnt[2:0];
            cache_wdata         = r_reg.rbuf[r_reg.vcnt[2:0]];
            cache_ram_byte_wr_n = BE_ALL;
         end
         ST_DELIVER:
         begin
            proc_stall_n        = 1'b0;
            proc_bus_drive_en_n = 1'b1;
            proc_latch_strobe_n = 1'b0;
         end
         ST_REEN:
         begin
            proc_stall_n = 1'b0;
         end
         ST_MERGE:
         begin
            proc_stall_n        = 1'b0;
            cache_ram_byte_wr_n = be_decode(req.size, req.paddr[1:0]);
         end
      endcase
   end

   // Memory side outputs
   assign mbus_req    = r_reg.count != 3'h0;
   assign mem_rd_addr = {req.paddr[ADDR_W-1:5], 5'h00};
   assign proc_rdata  = r_reg.rdata;
   always_comb
   begin
      mem_wr.valid = r_reg.dr_active;
      mem_wr.last  = dr_last;
      mem_wr.data  = r_reg.dr_word[0] ? dr_ent.w1 : dr_ent.w0;
      if (r_reg.line_mode)
         mem_wr.addr = {r_reg.wb[0].addr[ADDR_W-1:5], r_reg.dr_word, 2'h0};
      else
         mem_wr.addr = {dr_ent.addr[ADDR_W-1:3], dr_ent.addr[2] | r_reg.dr_word[0], 2'h0};
   end

   // ==========================================================
   // Next state
   always_comb
   begin
      r_next    = r_reg;
      push      = 1'b0;
      pop       = 1'b0;
      line_load = 1'b0;

      // Background drain, one transfer per entry or per line
      if (r_reg.dr_active && mem_wr_ready)
      begin
         if (dr_last)
         begin
            pop               = 1'b1;
            r_next.rptr       = r_reg.rptr + 2'h1;
            r_next.line_mode  = 1'b0;
            r_next.dr_word    = 3'h0;
            r_next.dr_active  = (r_reg.count > 3'h1) && mbus_grant;
         end
         else
            r_next.dr_word = r_reg.dr_word + 3'h1;
      end
      else if (!r_reg.dr_active && r_reg.count != 3'h0 && mbus_grant)
         r_next.dr_active = 1'b1;

      unique case (r_reg.state)
         ST_IDLE:
         begin
            if (req.valid && !req.write && !(req.cacheable && req.hit))
               r_next.state = ST_DRAIN;
            else if (req.valid && req.write && wt_path && !wb_full)
            begin
               push = 1'b1;
               r_next.wb[r_reg.wptr].dbl  = req.dbl;
               r_next.wb[r_reg.wptr].addr = req.paddr;
               r_next.wb[r_reg.wptr].w0   = req.wdata[63:32];
               r_next.wb[r_reg.wptr].w1   = req.wdata[31:0];
               r_next.wptr                = r_reg.wptr + 2'h1;
            end
            else if (req.valid && req.write && !wt_path && !req.hit)
               r_next.state = ST_DRAIN;
         end
         ST_DRAIN:
         begin
            if (r_reg.count == 3'h0 && !r_reg.dr_active)
            begin
               r_next.fcnt   = 4'h0;
               r_next.vcnt   = 4'h0;
               r_next.issued = 1'b0;
               r_next.state  = (req.write && req.dirty) ? ST_VICTIM : ST_FILL;
            end
         end
         ST_FILL:
         begin
            r_next.issued = 1'b1;
            if (mem_rd_valid)
            begin
               if (r_reg.fcnt[2:0] == req.paddr[4:2])
                  r_next.rdata = mem_rd_data;
               r_next.fcnt = r_reg.fcnt + 4'h1;
               if (r_reg.fcnt[2:0] == LAST_WORD)
                  r_next.state = req.write ? ST_REEN : ST_DELIVER;
            end
         end
         ST_VICTIM:
         begin
            r_next.issued = 1'b1;
            // Victim words leave the cache into the line store
            if (!r_reg.vcnt[3])
            begin
               if (r_reg.vcnt[0])
                  r_next.wb[r_reg.vcnt[2:1]].w1 = cache_rdata;
               else
                  r_next.wb[r_reg.vcnt[2:1]].w0 = cache_rdata;
               r_next.vcnt = r_reg.vcnt + 4'h1;
            end
            // New line words collect in the read buffer
            if (mem_rd_valid && !r_reg.fcnt[3])
            begin
               r_next.rbuf[r_reg.fcnt[2:0]] = mem_rd_data;
               r_next.fcnt                  = r_reg.fcnt + 4'h1;
               r_next.rb_valid              = r_reg.fcnt[2:0] == LAST_WORD;
            end
            if (r_reg.vcnt[3] && r_reg.fcnt[3])
            begin
               line_load          = 1'b1;
               r_next.wb[0].addr  = victim_addr;
               r_next.line_mode   = 1'b1;
               r_next.rptr        = 2'h0;
               r_next.wptr        = 2'h1;
               r_next.vcnt        = 4'h0;
               r_next.state       = ST_RBWR;
            end
         end
         ST_RBWR:
         begin
            r_next.vcnt = r_reg.vcnt + 4'h1;
            if (r_reg.vcnt[2:0] == LAST_WORD)
            begin
               r_next.rb_valid = 1'b0;
               r_next.state    = ST_REEN;
            end
         end
         ST_DELIVER:
            r_next.state = ST_REEN;
         ST_REEN:
            r_next.state = req.write ? ST_MERGE : ST_IDLE;
         ST_MERGE:
            r_next.state = ST_IDLE;
      endcase

      // Occupancy bookkeeping
      r_next.count = line_load ? 3'h1 : r_reg.count + {2'h0, push} - {2'h0, pop};
   end

   // Register the whole state; reset empties both buffers
   always_ff @(posedge clk)
   begin
      if (rst)
         r_reg <= CTRL_RESET;
      else if (ce)
         r_reg <= r_next;
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_strobe_under_stall: assert property (
      !proc_latch_strobe_n |-> !proc_stall_n && proc_bus_drive_en_n)
      else $error("latch strobe outside stall");
   a_drivers_before_release: assert property (
      $rose(proc_stall_n) |-> $past(!proc_bus_drive_en_n))
      else $error("stall released with drivers off");
   a_fill_all_bytes: assert property (
      (r_reg.state == ST_FILL && mem_rd_valid) |-> cache_ram_byte_wr_n == BE_ALL && proc_bus_drive_en_n)
      else $error("fill word written without all byte enables");
   a_victim_read_oe: assert property (
      (r_reg.state == ST_VICTIM && !r_reg.vcnt[3]) |-> !cache_ram_rd_oe_n)
      else $error("victim read without cache output enable");
   a_full_store_stall: assert property (
      (r_reg.state == ST_IDLE && req.valid && req.write && wt_path && r_reg.count == WBUF_FULL)
      |-> !proc_stall_n ##1 r_reg.count <= WBUF_FULL)
      else $error("store accepted into a full buffer");
   a_bus_request_held: assert property (
      (r_reg.count != 3'h0) |-> mbus_req)
      else $error("entries pending without bus request");
   a_read_after_empty: assert property (
      mem_rd_req |-> r_reg.count == 3'h0 && !r_reg.dr_active && !proc_stall_n)
      else $error("line fetch with write buffer not empty");
   a_line_not_mixed: assert property (
      r_reg.line_mode |-> r_reg.count == 3'h1)
      else $error("victim line shares the buffer");
   a_reset_clears: assert property (
      $fell(rst) |-> r_reg.count == 3'h0 && !r_reg.rb_valid)
      else $error("buffers valid after reset");
   a_deliver_then_reen: assert property (
      (r_reg.state == ST_DELIVER) |=> !proc_bus_drive_en_n && !proc_stall_n ##1 proc_stall_n)
      else $error("read miss ending out of order");
   a_parked_chain: assert property (
      (r_reg.dr_active && mem_wr_ready && dr_last && r_reg.count > 3'h1 && mbus_grant)
      |=> mem_wr.valid)
      else $error("idle clock between parked transfers");

   c_read_miss:   cover property (r_reg.state == ST_DELIVER);
   c_victim_fill: cover property (r_reg.state == ST_RBWR ##1 r_reg.dr_active);
   c_full_stall:  cover property (r_reg.count == WBUF_FULL && !proc_stall_n);
   c_clean_merge: cover property (r_reg.state == ST_MERGE);

endmodule

`default_nettype wire

// ==== mem_model.sv ====
// Purpose: Memory side partner: bus grant, line reads, word writes.
// Assumes: One clock; grant stays parked while requests continue.
// Notes:   Idle read data toggles so stale words never look valid.
`timescale 1ns/100ps
`default_nettype none

module mem_model
   import miss_ctrl_pkg::*;
(
   // Clock, reset, pacing
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              slow,
   input  wire logic              hold_wr,
   // Bus ownership and line read
   input  wire logic              mbus_req,
   output logic                   mbus_grant,
   input  wire logic              mem_rd_req,
   input  wire logic [ADDR_W-1:0] mem_rd_addr,
   output logic                   mem_rd_valid,
   output logic [WORD_W-1:0]      mem_rd_data,
   // Word writes
   input  wire mem_wr_type        mem_wr,
   output logic                   mem_wr_ready
);
   logic [ADDR_W-1:0] base;
   logic [3:0]        left;
   logic [2:0]        k;
   logic              tick;

   // ==========================================================
   // Grant follows request, line words return in order
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mbus_grant <= 1'b0;
         mem_rd_valid <= 1'b0;
         mem_rd_data <= '0;
         left <= 4'h0;
         tick <= 1'b0;
      end
      else
      begin
         mbus_grant <= mbus_req;
         tick <= ~tick;
         mem_rd_valid <= 1'b0;
         mem_rd_data <= ~mem_rd_data;
         if (mem_rd_req)
         begin
            base <= mem_rd_addr;
            left <= 4'h8;
            k <= 3'h0;
         end
         else if (left != 4'h0 && (!slow || tick))
         begin
            mem_rd_valid <= 1'b1;
            mem_rd_data <= base[31:0] + {27'h0, k, 2'h0};
            k <= k + 3'h1;
            left <= left - 4'h1;
         end
      end
   end

   // Writes accepted unless held back, every other cycle when slow
   assign mem_wr_ready = mem_wr.valid & ~hold_wr & (~slow | tick);
endmodule

`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the miss controller.
// Assumes: Tag lookup misses until the line has been refilled.
// Notes:   Memory side is mem_model; cache RAM is modelled inline.
`timescale 1ns/100ps
`default_nettype none

module tb_top
   import miss_ctrl_pkg::*;
;
   typedef struct packed {
      int fill, strobe, oe, inval, seq, drv;
      logic [3:0] be;
      logic stalled, busy;
   } obs_type;
   logic              clk, rst, ce, copy_back, slow, hold_wr, tag_inval;
   logic              proc_stall_n, proc_latch_strobe_n, proc_bus_drive_en_n;
   logic              cache_ram_rd_oe_n, mbus_req, mbus_grant, mem_rd_req;
   logic              mem_rd_valid, mem_wr_ready;
   logic [ADDR_W-1:0] victim_addr, mem_rd_addr, qa[$];
   logic [WORD_W-1:0] proc_rdata, cache_wdata, cache_rdata, mem_rd_data, got, qd[$];
   logic [31:0]       cyc = '0;
   logic [3:0]        cache_ram_byte_wr_n;
   logic [2:0]        cache_line_word;
   logic              ql[$];
   int                qt[$], bad_count, checks;
   proc_req_type      req;
   mem_wr_type        mem_wr;
   obs_type           o;

   miss_ctrl u_miss_ctrl (.clk, .rst, .ce, .req, .copy_back, .victim_addr, .proc_stall_n,
      .proc_latch_strobe_n, .proc_bus_drive_en_n, .proc_rdata, .cache_ram_rd_oe_n,
      .cache_ram_byte_wr_n, .cache_line_word, .cache_wdata, .cache_rdata, .tag_inval,
      .mbus_req, .mbus_grant, .mem_rd_req, .mem_rd_addr, .mem_rd_valid, .mem_rd_data,
      .mem_wr, .mem_wr_ready);
   mem_model u_mem_model (.clk, .rst, .slow, .hold_wr, .mbus_req, .mbus_grant, .mem_rd_req,
      .mem_rd_addr, .mem_rd_valid, .mem_rd_data, .mem_wr, .mem_wr_ready);

   // ==========================================================
   // Cache RAM read data, changing pattern when not enabled
   assign cache_rdata = cache_ram_rd_oe_n ? cyc : {16'hcace, 13'h0, cache_line_word};

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Log every accepted memory write word with its cycle
   always @(posedge clk)
   begin
      cyc <= cyc + 32'h1;
      if (mem_wr.valid === 1'b1 && mem_wr_ready === 1'b1)
      begin
         qa.push_back(mem_wr.addr);
         qd.push_back(mem_wr.data);
         ql.push_back(mem_wr.last);
         qt.push_back(cyc);
      end
   end

   // ==========================================================
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Issue one request, hold it while stalled, record what happens
   task automatic run_req(input logic wr, cb, nc, dbl, dirty, input logic [1:0] sz,
                          input logic [ADDR_W-1:0] pa, input logic [63:0] wd);
      int n;
      logic prev_drv;
      o = '0;
      o.be = BE_NONE;
      prev_drv = 1'b1;
      copy_back = cb;
      req = '{valid: 1'b1, write: wr, cacheable: !nc, dbl: dbl, hit: 1'b0, dirty: dirty,
              size: sz, paddr: pa, wdata: wd};
      for (n = 0; n < 400; n++)
      begin
         @(negedge clk);
         if (cache_ram_byte_wr_n === BE_ALL && proc_bus_drive_en_n === 1'b1)
         begin
            o.seq += (cache_line_word !== o.fill[2:0]);
            o.seq += (cache_wdata !== {pa[31:5], o.fill[2:0], 2'h0});
            o.fill++;
         end
         else if (cache_ram_byte_wr_n !== BE_NONE)
            o.be = cache_ram_byte_wr_n;
         if (proc_latch_strobe_n === 1'b0)
         begin
            o.strobe += (proc_stall_n === 1'b0) ? 1 : 100;
            got = proc_rdata;
         end
         o.oe += (cache_ram_rd_oe_n === 1'b0);
         o.inval += (tag_inval === 1'b1);
         o.busy |= (mem_rd_req === 1'b1 && mbus_req !== 1'b0);
         if (proc_stall_n === 1'b1)
            break;
         o.stalled = 1'b1;
         prev_drv = proc_bus_drive_en_n;
         @(posedge clk);
         #2;
         if (prev_drv === 1'b0 && o.fill != 0)
            req.hit = 1'b1;
      end
      chk("stall_release", proc_stall_n, 1);
      o.drv += (o.stalled && prev_drv !== 1'b0);
      @(posedge clk);
      #2;
      req.valid = 1'b0;
      @(negedge clk);
      o.inval += (tag_inval === 1'b1);
      @(posedge clk);
      #2;
   endtask

   task automatic drain();
      int n;
      for (n = 0; n < 300 && (mbus_req !== 1'b0 || mem_wr.valid !== 1'b0); n++)
         @(negedge clk);
      chk("drained", mbus_req, 0);
      @(posedge clk);
      #2;
   endtask

   // ==========================================================
   task automatic t_read(input logic cb);
      run_req(0, cb, 0, 0, 0, 2'h2, 36'h1_2345_6714, '0);
      chk("fill", o.fill, 8);
      chk("fill_word", o.seq, 0);
      chk("strobe", o.strobe, 1);
      chk("rdata", got, 32'h2345_6714);
      chk("drv_early", o.drv, 0);
      $display("test read miss done");
   endtask

   task automatic t_stores();
      logic [31:0] ed [6] = '{32'h1111_0000, 32'h2222_0000, 32'h2222_0001,
                              32'h3333_0000, 32'h4444_0000, 32'h5555_0000};
      logic [7:0] eo [6] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h20};
      int i;
      qa.delete();
      qd.delete();
      ql.delete();
      qt.delete();
      hold_wr = 1'b1;
      run_req(1, 0, 0, 0, 0, 2'h2, 36'h0_1000_0000, {32'h1111_0000, 32'h0});
      chk("inval", o.inval, 1);
      chk("bus_req", mbus_req, 1);
      run_req(1, 0, 0, 1, 0, 2'h2, 36'h0_1000_0008, {32'h2222_0000, 32'h2222_0001});
      run_req(1, 0, 0, 0, 0, 2'h2, 36'h0_1000_0010, {32'h3333_0000, 32'h0});
      run_req(1, 1, 1, 0, 0, 2'h2, 36'h0_1000_0018, {32'h4444_0000, 32'h0});
      chk("no_stall", o.stalled, 0);
      fork
         run_req(1, 0, 0, 0, 0, 2'h2, 36'h0_1000_0020, {32'h5555_0000, 32'h0});
         begin
            repeat (20) @(negedge clk);
            chk("full_stall", proc_stall_n, 0);
            @(posedge clk);
            #2;
            hold_wr = 1'b0;
         end
      join
      drain();
      chk("words", qa.size(), 6);
      for (i = 0; i < 6; i++)
      begin
         chk("wr_addr", qa[i], 36'h0_1000_0000 + eo[i]);
         chk("wr_data", qd[i], ed[i]);
         chk("wr_last", ql[i], i != 1);
         if (i > 0)
            chk("wr_gap", qt[i] - qt[i-1], 1);
      end
      $display("test write buffer done");
   endtask

   task automatic t_read_wait();
      qa.delete();
      hold_wr = 1'b1;
      run_req(1, 0, 0, 0, 0, 2'h0, 36'h0_2000_0001, {32'h0000_aa00, 32'h0});
      fork
         run_req(0, 0, 0, 0, 0, 2'h2, 36'h0_3000_0040, '0);
         begin
            repeat (10) @(posedge clk);
            #2;
            hold_wr = 1'b0;
         end
      join
      chk("rd_busy", o.busy, 0);
      chk("drained_first", qa.size(), 1);
      chk("fill", o.fill, 8);
      $display("test read wait done");
   endtask

   task automatic t_merge();
      logic [7:0] cs [8] = '{8'h0e, 8'h1d, 8'h2b, 8'h37, 8'h4c, 8'h63, 8'h80, 8'h5f};
      int i;
      for (i = 0; i < 8; i++)
      begin
         run_req(1, 1, 0, 0, 0, cs[i][7:6], {34'h0_4000_010, cs[i][5:4]}, 64'h0);
         chk("cb_fill", o.fill, 8);
         chk("merge_be", o.be, cs[i][3:0]);
      end
      $display("test merge done");
   endtask

   task automatic t_victim();
      int k;
      qa.delete();
      qd.delete();
      ql.delete();
      slow = 1'b1;
      victim_addr = 36'h8_7654_3200;
      run_req(1, 1, 0, 0, 1, 2'h0, 36'h0_5000_0120, {32'hab00_0000, 32'h0});
      drain();
      chk("rbuf_fill", o.fill, 8);
      chk("rbuf_data", o.seq, 0);
      chk("victim_rd", o.oe >= 8, 1);
      chk("merge_be", o.be, 4'he);
      chk("victim_words", qa.size(), 8);
      for (k = 0; k < 8; k++)
      begin
         chk("v_addr", qa[k], victim_addr + 4 * k);
         chk("v_data", qd[k], {16'hcace, 13'h0, k[2:0]});
         chk("v_last", ql[k], k == 7);
      end
      slow = 1'b0;
      $display("test victim done");
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      copy_back = 1'b0;
      slow = 1'b0;
      hold_wr = 1'b0;
      victim_addr = '0;
      req = '0;
      repeat (12) @(posedge clk);
      #2;
      rst = 1'b0;
      @(negedge clk);
      chk("stall_n", proc_stall_n, 1);
      chk("bus_req", mbus_req, 0);
      chk("wr_valid", mem_wr.valid, 0);
      chk("byte_wr", cache_ram_byte_wr_n, BE_NONE);
      $display("test reset done");
      @(posedge clk);
      #2;
      t_read(1'b0);
      t_read(1'b1);
      t_stores();
      t_read_wait();
      t_merge();
      t_victim();
      summarize();
   end

   // Watchdog against a hung handshake
   initial
   begin
      repeat (6000) @(posedge clk);
      bad_count++;
      summarize();
   end
endmodule

`default_nettype wire
